// File: design/dcm_ctrl.sv
// controller for the special command modes of a ddr4 device: parity alert
// watch, command/address latency, max power saving entry/exit, test entry
// assumes an axi4-lite master on sys_clk and the device clock gated by ck_en
`timescale 1ns/100ps
module dcm_ctrl
	import dcm_pkg::*;
#(
	parameter int P_CPDED_CK = 4,   // command path disable delay, CK
	parameter int P_CKSRX_CK = 8,   // clock lead before exit, CK
	parameter int P_XS_CK    = 120, // exit delay without dll, CK
	parameter int P_XSDLL_CK = 768, // extra dll lock delay, CK
	parameter int P_XP_NS    = 6,   // select high hold after cke, ns
	parameter int P_MPXS_NS  = 1    // select setup to cke, ns
) (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             ddr_ck_en,
	output logic             ddr_cke,
	output logic             ddr_cs_n,
	output logic             ddr_ten,
	output logic [23:0]      ddr_cmd,
	input  wire logic        ddr_alert_n
);
	localparam int MPED_CYC = MOD_CYC + P_CPDED_CK;
	localparam int XP_CYC   = ns_min(P_XP_NS);
	localparam int MPXS_CYC = ns_min(P_MPXS_NS);
	localparam int XREST    = P_XS_CK - MPX_LH_CYC - XP_CYC;

	dcm_state_t  state_ff;
	logic [15:0] tmr_ff;
	logic [31:0] ctrl_ff;
	logic [23:0] cmd_reg_ff;
	logic        cmd_pend_ff, mps_in_ff, mps_out_ff, tst_in_ff, tst_out_ff;
	logic        alert_s1_ff, alert_s2_ff, alert_d_ff;
	logic [7:0]  width_ff, last_w_ff;
	logic        seen_ff, werr_ff, unc_ff, dll_ok_ff, rsp_late_ff;
	logic [7:0]  hist_ff, rsp_ff;
	logic [1:0]  bresp_ff;
	logic [1:0]  grade;
	logic        wr_go, rd_go, clr, blocked, issue, take_cmd, on_rise;
	logic        off_fall, tmr_done;
	logic [31:0] wmask, stat;
	logic [3:0]  lat, unc_len;
	logic [7:0]  unc_mask;

	// grade 3 is not a real grade, fall back to the highest
	assign grade    = (ctrl_ff[C_GRADE+:2] == 2'h3) ? 2'h2
		: ctrl_ff[C_GRADE+:2];
	assign lat      = ctrl_ff[C_GEAR] ? CALG_LAT[grade]
		: CAL_LAT[grade];
	assign tmr_done = (tmr_ff == 16'h0000);

	// bus handshake: write address and data taken together
	assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign rd_go         = s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_arready = rd_go;
	assign s_axi_bresp   = bresp_ff;
	for (genvar i = 0; i < 4; i++) begin : g_strb
		assign wmask[8*i+:8] = {8{s_axi_wstrb[i]}};
	end
	assign clr = wr_go && s_axi_awaddr == REG_CTRL && s_axi_wstrb[1]
		&& s_axi_wdata[C_CLR];

	// write response, unmapped offsets answer decode error
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_bvalid <= 1'b0;
			bresp_ff     <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			bresp_ff     <= (s_axi_awaddr == REG_CTRL
				|| s_axi_awaddr == REG_CMD) ? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// sticky control bits and the command word
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_ff    <= 32'h0000_0000;
			cmd_reg_ff <= 24'h00_0000;
		end else if (wr_go && s_axi_awaddr == REG_CTRL) begin
			ctrl_ff <= ((ctrl_ff & ~wmask) | (s_axi_wdata & wmask))
				& CTRL_KEEP;
		end else if (wr_go && s_axi_awaddr == REG_CMD) begin
			cmd_reg_ff <= ((cmd_reg_ff & ~wmask[23:0])
				| (s_axi_wdata[23:0] & wmask[23:0]));
		end
	end

	// request flags; a new request wins over the one being taken
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_pend_ff <= 1'b0;
			mps_in_ff   <= 1'b0;
			mps_out_ff  <= 1'b0;
			tst_in_ff   <= 1'b0;
			tst_out_ff  <= 1'b0;
		end else begin
			cmd_pend_ff <= (cmd_pend_ff && !take_cmd)
				|| (wr_go && s_axi_awaddr == REG_CMD);
			mps_in_ff  <= (mps_in_ff && !(state_ff == ST_IDLE && !blocked
				&& !tst_in_ff)) || (clr_pulse(C_MPS_IN));
			mps_out_ff <= (mps_out_ff && state_ff != ST_MPS)
				|| clr_pulse(C_MPS_OUT);
			tst_in_ff  <= (tst_in_ff && state_ff != ST_IDLE)
				|| clr_pulse(C_TST_IN);
			tst_out_ff <= (tst_out_ff && state_ff != ST_TST)
				|| clr_pulse(C_TST_OUT);
		end
	end

	function automatic logic clr_pulse(input int bitpos);
		return wr_go && s_axi_awaddr == REG_CTRL && s_axi_wstrb[1]
			&& s_axi_wdata[bitpos];
	endfunction

	// alert pin synchroniser; only the second stage and the delay stage after it are looked at
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			alert_s1_ff <= 1'b1;
			alert_s2_ff <= 1'b1;
			alert_d_ff  <= 1'b1;
		end else begin
			alert_s1_ff <= ddr_alert_n;
			alert_s2_ff <= alert_s1_ff;
			alert_d_ff  <= alert_s2_ff;
		end
	end
	assign on_rise  = alert_d_ff && !alert_s2_ff;
	assign off_fall = !alert_d_ff && alert_s2_ff;

	// pulse width check; width saturates so a long pulse still flags once it ends
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			width_ff  <= 8'h00;
			last_w_ff <= 8'h00;
			werr_ff   <= 1'b0;
		end else begin
			if (on_rise)
				width_ff <= 8'h01;
			else if (!alert_s2_ff && width_ff != 8'hff)
				width_ff <= width_ff + 8'h01;
			if (off_fall)
				last_w_ff <= width_ff;
			werr_ff <= (werr_ff && !clr) || (off_fall
				&& (width_ff < PW_MIN[grade]
				|| width_ff > PW_MAX[grade]));
		end
	end

	// commands inside parity latency plus pin delay may not have run
	assign unc_len  = PAR_LAT[grade] + 4'(ALERT_XCYC);
	assign unc_mask = 8'((9'h001 << unc_len) - 9'h001);
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			hist_ff <= 8'h00;
			seen_ff <= 1'b0;
			unc_ff  <= 1'b0;
		end else begin
			hist_ff <= {hist_ff[6:0], issue};
			seen_ff <= (seen_ff && !clr) || on_rise;
			unc_ff  <= (unc_ff && !clr)
				|| (on_rise && |(hist_ff & unc_mask));
		end
	end

	// time since the last alert, saturating, for software to see; late flag on a select past the limit in persistent mode
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rsp_ff      <= 8'h00;
			rsp_late_ff <= 1'b0;
		end else begin
			if (on_rise)
				rsp_ff <= 8'h00;
			else if (rsp_ff != 8'hff)
				rsp_ff <= rsp_ff + 8'h01;
			rsp_late_ff <= (rsp_late_ff && !clr) || (issue && seen_ff
				&& ctrl_ff[C_PERSIST] && rsp_ff > RSP_MAX[grade]);
		end
	end

	// persistent parity holds commands off until software clears alert
	assign blocked  = ctrl_ff[C_PERSIST] && seen_ff;
	assign take_cmd = state_ff == ST_IDLE && cmd_pend_ff && !blocked
		&& !tst_in_ff && !mps_in_ff;
	assign issue    = !ddr_cs_n;

	// sequencer: one timer, each wait state leaves when it reaches zero
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff  <= ST_IDLE;
			tmr_ff    <= 16'h0000;
			ddr_ck_en <= 1'b1;
			ddr_cke   <= 1'b1;
			ddr_cs_n  <= 1'b1;
			ddr_ten   <= 1'b0;
			ddr_cmd   <= 24'h00_0000;
			dll_ok_ff <= 1'b1;
		end else if (!tmr_done) begin
			tmr_ff   <= tmr_ff - 16'h0001;
			ddr_cs_n <= (state_ff == ST_CAL || state_ff == ST_MPS_HOLD)
				? 1'b1 : ddr_cs_n;
		end else begin
			unique case (state_ff)
			ST_IDLE: begin
				ddr_cs_n <= 1'b1;
				if (tst_in_ff) begin
					ddr_ten  <= 1'b1;
					tmr_ff   <= 16'(TST_CK_CYC - 1);
					state_ff <= ST_TST_CLK;
				end else if (mps_in_ff && !blocked) begin
					ddr_cs_n  <= 1'b0;
					ddr_cmd   <= cmd_reg_ff;
					dll_ok_ff <= 1'b0;
					tmr_ff    <= 16'(MPED_CYC - 1);
					state_ff  <= ST_MPS_HOLD;
				end else if (take_cmd) begin
					ddr_cs_n <= 1'b0;
					ddr_cmd  <= cmd_reg_ff;
					if (ctrl_ff[C_CAL]) begin
						tmr_ff   <= 16'(lat);
						state_ff <= ST_CAL;
					end
				end
			end
			ST_CAL: begin
				ddr_cs_n <= 1'b1;
				state_ff <= ST_IDLE;
			end
			ST_MPS_HOLD: begin
				ddr_ck_en <= 1'b0; // clock may stop only now
				ddr_cke   <= 1'b0;
				state_ff  <= ST_MPS;
			end
			ST_MPS: begin
				if (mps_out_ff) begin
					ddr_ck_en <= 1'b1;
					tmr_ff    <= 16'(P_CKSRX_CK - 1);
					state_ff  <= ST_MPX_LEAD;
				end
			end
			ST_MPX_LEAD: begin
				ddr_cs_n <= 1'b0;
				tmr_ff   <= 16'(MPXS_CYC - 1);
				state_ff <= ST_MPX_SETUP;
			end
			ST_MPX_SETUP: begin
				ddr_cke  <= 1'b1;
				tmr_ff   <= 16'(MPX_LH_CYC - 1);
				state_ff <= ST_MPX_LOW;
			end
			ST_MPX_LOW: begin
				ddr_cs_n <= 1'b1;
				tmr_ff   <= 16'(XP_CYC - 1);
				state_ff <= ST_MPX_HIGH;
			end
			ST_MPX_HIGH: begin
				tmr_ff   <= 16'(XREST - 1);
				state_ff <= ST_MPX_WAIT;
			end
			ST_MPX_WAIT: begin
				tmr_ff   <= 16'(P_XSDLL_CK - 1);
				state_ff <= ST_MPX_DLL;
			end
			ST_MPX_DLL: begin
				dll_ok_ff <= 1'b1;
				state_ff  <= ST_IDLE;
			end
			ST_TST_CLK: begin
				ddr_ck_en <= 1'b1;
				ddr_cke   <= 1'b1;
				tmr_ff    <= 16'(TST_EN_CYC - TST_CK_CYC - 1);
				state_ff  <= ST_TST_CS;
			end
			ST_TST_CS: begin
				ddr_cs_n <= 1'b0;
				tmr_ff   <= 16'(TST_VD_CYC - 1);
				state_ff <= ST_TST_WAIT;
			end
			ST_TST_WAIT: state_ff <= ST_TST;
			ST_TST: begin
				if (tst_out_ff) begin
					ddr_ten  <= 1'b0;
					ddr_cs_n <= 1'b1;
					state_ff <= ST_IDLE;
				end
			end
			endcase
		end
	end

	// status word
	assign stat = {16'h0000, 3'h0, rsp_late_ff, state_ff,
		(state_ff == ST_TST), dll_ok_ff,
		(state_ff == ST_MPX_DLL || dll_ok_ff), (state_ff == ST_MPS),
		unc_ff, werr_ff, seen_ff, blocked};

	// read channel, unmapped offsets read zero with decode error
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			unique case (s_axi_araddr)
			REG_CTRL:  s_axi_rdata <= ctrl_ff;
			REG_CMD:   s_axi_rdata <= {8'h00, cmd_reg_ff};
			REG_STAT:  s_axi_rdata <= stat;
			REG_ALERT: s_axi_rdata <= {16'h0000, rsp_ff, last_w_ff};
			default: begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= RESP_DECERR;
			end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// File: design/dcm_pkg.sv
// constants, register map and state type for the command-mode sequencer
// assumes the memory clock is sys_clk itself, so one CK is one sys_clk cycle
package dcm_pkg;
	localparam int CLK_PS = 4000; // sys_clk period in ps

	// ns figure to whole cycles, rounded up for least times
	function automatic int ns_min(input int ns);
		return (ns * 1000 + CLK_PS - 1) / CLK_PS;
	endfunction

	// times in their own unit
	localparam int MOD_NCK        = 24;
	localparam int MOD_NS         = 15;
	localparam int MPX_LH_NS      = 12;
	localparam int TST_ENTRY_NS   = 200;
	localparam int TST_VALID_NS   = 200;
	localparam int TST_CLK_NS     = 10;
	localparam int ALERT_EXTRA_NS = 6;

	// derived cycle counts
	localparam int MOD_CYC    = (ns_min(MOD_NS) > MOD_NCK) ?
		ns_min(MOD_NS) : MOD_NCK;
	localparam int MPX_LH_CYC = ns_min(MPX_LH_NS);
	localparam int TST_EN_CYC = ns_min(TST_ENTRY_NS);
	localparam int TST_VD_CYC = ns_min(TST_VALID_NS);
	localparam int TST_CK_CYC = ns_min(TST_CLK_NS);
	localparam int ALERT_XCYC = ns_min(ALERT_EXTRA_NS);

	// per speed grade: 0 lowest, 1 middle, 2 highest
	localparam logic [7:0] PW_MIN [0:2] = '{8'h50, 8'h58, 8'h60};
	localparam logic [7:0] PW_MAX [0:2] = '{8'ha0, 8'hb0, 8'hc0};
	localparam logic [7:0] RSP_MAX [0:2] = '{8'h47, 8'h4e, 8'h55};
	localparam logic [3:0] CAL_LAT [0:2] = '{4'h5, 4'h6, 4'h6};
	localparam logic [3:0] CALG_LAT [0:2] = '{4'h6, 4'h8, 4'h8};
	localparam logic [3:0] PAR_LAT [0:2] = '{4'h5, 4'h6, 4'h6};

	// register map, byte addresses
	localparam logic [7:0] REG_CTRL  = 8'h00;
	localparam logic [7:0] REG_CMD   = 8'h04;
	localparam logic [7:0] REG_STAT  = 8'h08;
	localparam logic [7:0] REG_ALERT = 8'h0c;

	// control fields
	localparam int C_GRADE   = 0; // two bits
	localparam int C_CAL     = 2;
	localparam int C_GEAR    = 3;
	localparam int C_PERSIST = 4;
	localparam int C_MPS_IN  = 8; // pulse bits from here up
	localparam int C_MPS_OUT = 9;
	localparam int C_TST_IN  = 10;
	localparam int C_TST_OUT = 11;
	localparam int C_CLR     = 12;
	localparam logic [31:0] CTRL_KEEP = 32'h0000_001f;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [3:0] {
		ST_IDLE, ST_CAL, ST_MPS_HOLD, ST_MPS, ST_MPX_LEAD, ST_MPX_SETUP,
		ST_MPX_LOW, ST_MPX_HIGH, ST_MPX_WAIT, ST_MPX_DLL,
		ST_TST_CLK, ST_TST_CS, ST_TST_WAIT, ST_TST
	} dcm_state_t;
endpackage

// File: verification/dcm_ctrl_properties.sv
// pin checker for the command-mode sequencer
// assumes a bind into dcm_ctrl, one memory clock per sys_clk cycle
`timescale 1ns/100ps
module dcm_ctrl_properties
	import dcm_pkg::*;
#(
	parameter int P_CKSRX_CK = 8
) (
	input wire logic        sys_clk,
	input wire logic        reset_n,
	input wire logic        ddr_ck_en,
	input wire logic        ddr_cke,
	input wire logic        ddr_cs_n,
	input wire logic        ddr_ten,
	input wire logic [23:0] ddr_cmd,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid
);
	logic [7:0] ten_ff;
	logic [7:0] ck_ff;
	logic [7:0] cs_ff;
	logic       cal_ff;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	// saturating run lengths, a wrap would fake a short lead
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ten_ff <= 8'h00;
			ck_ff <= 8'h00;
			cs_ff <= 8'h00;
		end else begin
			ten_ff <= !ddr_ten ? 8'h00 : ten_ff + {7'h00, ten_ff != 8'hff};
			ck_ff <= !ddr_ck_en ? 8'h00 : ck_ff + {7'h00, ck_ff != 8'hff};
			cs_ff <= !ddr_cs_n ? 8'h00 : cs_ff + {7'h00, cs_ff != 8'hff};
		end
	end

	// cal enable mirrored from accepted control writes; without it
	// plain commands may follow each other two cycles apart
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			cal_ff <= 1'b0;
		else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid
			&& s_axi_awaddr == REG_CTRL && s_axi_wstrb[0])
			cal_ff <= s_axi_wdata[C_CAL];
	end

	// exit pulse: low through the hold, then back high soon
	sequence exit_low_s;
		!ddr_cs_n [*3] ##[1:5] ddr_cs_n;
	endsequence
	sequence cal_quiet_s;
		(ddr_cs_n && $stable(ddr_cmd)) [*5];
	endsequence

	ten_lead_a: assert property (
		$fell(ddr_cs_n) && ddr_ten |-> ten_ff >= TST_EN_CYC - 1)
		else $error("select fell too soon after test enable");
	test_clk_a: assert property (
		$rose(ddr_ten) |-> ##[0:3] (ddr_ck_en && ddr_cke))
		else $error("clock not valid after test enable");
	entry_clk_a: assert property (
		$fell(ddr_ck_en) |-> cs_ff >= MOD_CYC)
		else $error("clock stopped too soon after entry");
	exit_lead_a: assert property (
		$fell(ddr_cs_n) && !ddr_cke |-> ck_ff >= P_CKSRX_CK - 1)
		else $error("clock lead before exit too short");
	cs_setup_a: assert property ($rose(ddr_cke) |-> !$past(ddr_cs_n))
		else $error("select not set up before cke");
	low_hold_a: assert property ($rose(ddr_cke) |-> exit_low_s)
		else $error("select low hold wrong at exit");
	high_hold_a: assert property (
		$rose(ddr_cs_n) && !$past(ddr_cs_n, 3) |-> ddr_cs_n [*2])
		else $error("select high hold too short");
	cal_hold_a: assert property (
		$fell(ddr_cs_n) && ddr_cke && !ddr_ten && cal_ff |=> cal_quiet_s)
		else $error("command word moved inside latency");
endmodule

bind dcm_ctrl dcm_ctrl_properties #(.P_CKSRX_CK(P_CKSRX_CK)) u_props (
	.sys_clk(sys_clk), .reset_n(reset_n), .ddr_ck_en(ddr_ck_en),
	.ddr_cke(ddr_cke), .ddr_cs_n(ddr_cs_n), .ddr_ten(ddr_ten),
	.ddr_cmd(ddr_cmd), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
	.s_axi_wvalid(s_axi_wvalid));

// File: verification/dcm_dev_model.sv
// memory device model: parity check on commands, alert pulse
// assumes even parity over the command word, alert pin pulled up
`timescale 1ns/100ps
module dcm_dev_model #(
	parameter logic [7:0] LAT_CYC = 8'h05
) (
	input wire logic        sys_clk,
	input wire logic        reset_n,
	input wire logic        ddr_ck_en,
	input wire logic        ddr_cke,
	input wire logic        ddr_cs_n,
	input wire logic        ddr_ten,
	input wire logic [23:0] ddr_cmd,
	input wire logic [7:0]  pulse_w,
	output logic            ddr_alert_n
);
	logic [7:0] dly_ff;
	logic [7:0] pw_ff;

	// no command decode with cke low or clock stopped: path disabled
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			dly_ff <= 8'h00;
			pw_ff <= 8'h00;
		end else begin
			if (!ddr_cs_n && ddr_cke && ddr_ck_en && !ddr_ten && ^ddr_cmd)
				dly_ff <= LAT_CYC;
			else if (dly_ff != 8'h00)
				dly_ff <= dly_ff - 8'h01;
			if (dly_ff == 8'h01)
				pw_ff <= pulse_w;
			else if (pw_ff != 8'h00)
				pw_ff <= pw_ff - 8'h01;
		end
	end
	assign ddr_alert_n = (pw_ff == 8'h00); // open drain, idles high
endmodule

// File: verification/dcm_ctrl_tb_top.sv
// bench for the command-mode sequencer: axi master, pin monitor, tests
// assumes the device model on the pins and the checker bound to the dut
`timescale 1ns/100ps
module dcm_ctrl_tb_top
	import dcm_pkg::*;
;
	localparam int XS = 10;
	localparam int XSDLL = 8;
	logic        sys_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, pulse_w = 8'h64;
	logic [31:0] wdata = 32'h0, rdata;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic        ck_en, cke, cs_n, ten, alert_n;
	logic        cs_q = 1'b1, ck_q = 1'b1, cke_q = 1'b1, ten_q = 1'b0;
	logic [23:0] cmd;
	int          err_total, comparisons, cyc, fall_t, gap, nfall;
	int          ckf_t, cker_t, tenr_t;

	dcm_ctrl #(.P_XS_CK(XS), .P_XSDLL_CK(XSDLL)) u_dut (
		.sys_clk(sys_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ddr_ck_en(ck_en), .ddr_cke(cke),
		.ddr_cs_n(cs_n), .ddr_ten(ten), .ddr_cmd(cmd),
		.ddr_alert_n(alert_n));
	dcm_dev_model u_dev (
		.sys_clk(sys_clk), .reset_n(reset_n), .ddr_ck_en(ck_en),
		.ddr_cke(cke), .ddr_cs_n(cs_n), .ddr_ten(ten), .ddr_cmd(cmd),
		.pulse_w(pulse_w), .ddr_alert_n(alert_n));

	always #2 sys_clk = ~sys_clk;

	// pin event times in cycles; the hang limit sits here too
	always @(posedge sys_clk) begin
		{cs_q, ck_q, cke_q, ten_q} <= {cs_n, ck_en, cke, ten};
		cyc <= cyc + 1;
		if (cs_q && !cs_n) begin
			gap <= cyc - fall_t;
			fall_t <= cyc;
			nfall <= nfall + 1;
		end
		if (ck_q && !ck_en) ckf_t <= cyc;
		if (!cke_q && cke) cker_t <= cyc;
		if (!ten_q && ten) tenr_t <= cyc;
		if (cyc > 20000) begin
			err_total++;
			stop_test;
		end
	end

	task automatic chk(input logic [31:0] seen, exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// address and data offered together; the extra edge avoids
	// lowering and raising bready in one time step
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge sys_clk); while (!(awready && wready));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge sys_clk); while (!bvalid);
		chk(bresp, er, "write response");
		bready <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [1:0] er,
		output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge sys_clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge sys_clk); while (!rvalid);
		d = rdata;
		chk(rresp, er, "read response");
		rready <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic poll(input int b);
		logic [31:0] d;
		do rd(REG_STAT, RESP_OKAY, d); while (d[b] !== 1'b1);
	endtask

	task automatic t_regs;
		logic [31:0] d;
		rd(REG_CTRL, RESP_OKAY, d);
		chk(d, 32'h0, "ctrl reset");
		rd(8'h10, RESP_DECERR, d);
		chk(d, 32'h0, "unmapped read");
		wr(REG_STAT, 32'h1, RESP_DECERR);
		$display("regs test done");
	endtask

	// second command waits in the queue behind the first
	task automatic t_cal;
		int lat;
		for (int g = 0; g < 3; g++) begin
			for (int gr = 0; gr < 2; gr++) begin
				lat = gr ? CALG_LAT[g] : CAL_LAT[g];
				wr(REG_CTRL, 32'h4 | (gr << 3) | g, RESP_OKAY);
				wr(REG_CMD, 32'h3, RESP_OKAY);
				wr(REG_CMD, 32'h5, RESP_OKAY);
				repeat (12) @(posedge sys_clk);
				chk(32'(gap > lat && gap <= lat + 3), 32'h1, "cal gap");
			end
		end
		$display("cal test done");
	endtask

	task automatic t_alert;
		logic [31:0] d;
		int n;
		wr(REG_CTRL, 32'h1010, RESP_OKAY);
		wr(REG_CMD, 32'h1, RESP_OKAY);
		repeat (20) @(posedge sys_clk);
		rd(REG_STAT, RESP_OKAY, d);
		chk(d[2:0], 32'h3, "alert blocked");
		n = nfall;
		wr(REG_CMD, 32'h3, RESP_OKAY);
		repeat (10) @(posedge sys_clk);
		chk(nfall, n, "blocked command");
		repeat (120) @(posedge sys_clk);
		rd(REG_ALERT, RESP_OKAY, d);
		chk(d[7:0], 32'h64, "alert width");
		pulse_w <= 8'h3c;
		wr(REG_CTRL, 32'h1000, RESP_OKAY);
		wr(REG_CMD, 32'h1, RESP_OKAY);
		repeat (90) @(posedge sys_clk);
		rd(REG_STAT, RESP_OKAY, d);
		chk(d[2], 1'b1, "short alert");
		$display("alert test done");
	endtask

	task automatic t_mps;
		int n;
		wr(REG_CTRL, 32'h1000, RESP_OKAY);
		wr(REG_CMD, 32'h600, RESP_OKAY);
		wr(REG_CTRL, 32'h100, RESP_OKAY);
		repeat (40) @(posedge sys_clk);
		chk(32'(ckf_t - fall_t >= MOD_CYC + 4), 32'h1, "entry hold");
		chk(32'(cmd), 32'h600, "entry word");
		n = nfall;
		wr(REG_CMD, 32'h3, RESP_OKAY);
		chk(nfall, n, "command in power save");
		wr(REG_CTRL, 32'h200, RESP_OKAY);
		poll(5);
		chk(32'(cyc - cker_t >= XS), 32'h1, "exit delay");
		poll(6);
		chk(32'(cyc - cker_t >= XS + XSDLL), 32'h1, "dll delay");
		$display("power save test done");
	endtask

	task automatic t_ct;
		wr(REG_CTRL, 32'h400, RESP_OKAY);
		poll(7);
		chk(32'(cyc - fall_t >= TST_VD_CYC), 32'h1, "test valid wait");
		chk(32'(fall_t - tenr_t >= TST_EN_CYC), 32'h1, "test lead");
		chk({ck_en, cke}, 32'h3, "test clock");
		wr(REG_CTRL, 32'h800, RESP_OKAY);
		chk(ten, 1'b0, "test leave");
		$display("test mode test done");
	endtask

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		t_regs;
		t_cal;
		t_alert;
		t_mps;
		t_ct;
		stop_test;
	end
endmodule
